/* File: shared/pf_regs.svh */
// Register offsets, field positions, reset values and build choices of the descriptor prefetcher.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef PF_REGS_SVH
`define PF_REGS_SVH
// APB byte offsets.
`define CTRL_OFF 8'h00
`define NPTR_OFF 8'h04
`define POLL_OFF 8'h08
`define STAT_OFF 8'h0c
// Control and status field positions.
`define CTRL_RUN 0
`define CTRL_POLL 1
`define CTRL_RST 2
`define CTRL_GIE 3
`define STAT_IRQ 0
`define STAT_BUSY 1
`define POLL_W 16
// Reset values.
`define NPTR_RST 32'h00000000
`define POLL_RST 16'h0000
// Build choices.
`define PREFETCH_EN 1'b1
`define BURST_EN 1'b1
`define MAX_BURST 5'h10
`define EXT_EN 1'b0
`define DESC_BEATS (`EXT_EN ? 2'h2 : 2'h1)
`define DESC_DW 256
`define DESC_BEW 32
`define PTR_DEPTH 8
`define PTR_AW 3
// Descriptor layout in the last fetched beat, and write-back placement.
`define DESC_NEXT_LSB 96
`define DESC_OWNER_BIT 254
`define WB_BYTES_LSB 128
`define WB_ERR_LSB 160
`define WB_EARLY_BIT 168
`define WB_BE 32'h003f0000
`endif

/* File: shared/pf_pkg.sv */
// Types shared by the descriptor prefetcher files.
// Assumes nothing of its surroundings.
package pf_pkg;
   typedef enum logic [2:0] {F_IDLE, F_RD, F_DATA, F_SEND, F_POLL} fetch_st_t;
   typedef enum logic [1:0] {W_IDLE, W_RD, W_WR} wb_st_t;
   typedef struct packed {
      logic [203:0] rsvd;
      logic buf_full;
      logic et_mask;
      logic [7:0] err_mask;
      logic tc_mask;
      logic early;
      logic [7:0] err;
      logic [31:0] bytes;
   } resp_t;
endpackage

/* File: src/ptr_mem.sv */
// Small memory holding descriptor addresses that wait for status write-back.
// Assumes the owner keeps the pointers; read data appear one edge after re.
`timescale 1ns/10ps
module ptr_mem #(
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   // Clock and reset.
   input logic pclk,
   input logic presetn,
   // Write port.
   input logic we,
   input logic [AW-1:0] waddr,
   input logic [31:0] wdata,
   // Read port.
   input logic re,
   input logic [AW-1:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [DEPTH];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 32'h00000000;
      end else if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

/* File: src/desc_prefetch.sv */
// Descriptor prefetcher: fetches descriptors, feeds the dispatcher, takes its
// responses, writes status back and raises the interrupt.
// Assumes one clock, an APB master for registers and a dispatcher on the streams.
//
// Function
// - Prefetcher drives response ready, may stall
// - Response bytes, error, early flag, buffer full
// - Response carries completion, error, early masks
// - Interrupt comes from prefetcher when enabled
// - Interrupt only for events whose mask set; code also sets it at an unowned list end without polling
// - Own global enable and interrupt status
// - Unowned descriptor ends list processing
// - Pointer load plus run bit starts
// - No polling: interrupt at end, stop
// - Polling: follow next pointer without software
// - Polling: refetch until owner flag set
// - Write status back into each descriptor
// - Control bit two resets, self clears
// - Read burst length is build choice
// - Descriptor data width is build choice
// - Extended option sets descriptor length
// - Depth sizes write-back pointer buffer
// - Status flag set by hardware, write-one-clear
// - Poll interval counts from read data
`timescale 1ns/10ps
`include "pf_regs.svh"
module desc_prefetch
   import pf_pkg::*;
(
   // Clock and reset.
   input logic pclk,
   input logic presetn,
   // APB register slave.
   input logic [7:0] paddr,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Descriptor fetch port.
   output logic rd_read,
   output logic [31:0] rd_addr,
   output logic [4:0] rd_burst,
   input logic rd_wait,
   input logic rd_valid,
   input logic [`DESC_DW-1:0] rd_data,
   // Descriptor write-back port.
   output logic wr_write,
   output logic [31:0] wr_addr,
   output logic [`DESC_DW-1:0] wr_data,
   output logic [`DESC_BEW-1:0] wr_be,
   input logic wr_wait,
   // Descriptor source to the dispatcher.
   output logic src_valid,
   output logic [`DESC_DW-1:0] src_data,
   input logic src_ready,
   // Completion responses from the dispatcher.
   input logic rsp_valid,
   input resp_t rsp_data,
   output logic rsp_ready,
   // Interrupt.
   input logic disp_irq,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] burst_len(input logic en);
      return en ? {3'h0, `DESC_BEATS} : 5'h01;
   endfunction

   function automatic logic ptr_eq(input logic [`PTR_AW:0] a, input logic [`PTR_AW:0] b);
      return a[`PTR_AW-1:0] == b[`PTR_AW-1:0];
   endfunction

   logic run_ff, poll_ff, rst_ff, gie_ff, irq_ff;
   logic nxt_run, nxt_rst, nxt_irq;
   logic [31:0] nptr_ff, nxt_nptr, prdata_ff, next_ff;
   logic [15:0] pollv_ff, cnt_ff;
   logic [1:0] beat_ff, nxt_beat;
   logic [`DESC_DW-1:0] desc_ff, wb_word;
   logic [`PTR_AW:0] wp_ff, rp_ff;
   logic [31:0] mem_q;
   fetch_st_t fst_ff, nxt_fst;
   wb_st_t wst_ff, nxt_wst;
   resp_t rsp_ff;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode. The slave never waits; read data are caught in the setup cycle.
   wire apb_wr = psel & penable & pwrite;
   wire apb_setup_rd = psel & ~penable & ~pwrite;
   wire hit_ctrl = paddr == `CTRL_OFF;
   wire hit_nptr = paddr == `NPTR_OFF;
   wire hit_poll = paddr == `POLL_OFF;
   wire hit_stat = paddr == `STAT_OFF;
   wire hit_any = hit_ctrl | hit_nptr | hit_poll | hit_stat;
   wire ctrl_wr = apb_wr & hit_ctrl;
   wire nptr_wr = apb_wr & hit_nptr;
   wire poll_wr = apb_wr & hit_poll;
   wire stat_wr = apb_wr & hit_stat;
   wire busy = (fst_ff != F_IDLE) | (wst_ff != W_IDLE);
   wire [31:0] ctrl_rd = {28'h0000000, gie_ff, rst_ff, poll_ff, run_ff};
   wire [31:0] stat_rd = {30'h0, busy, irq_ff};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                        hit_nptr ? nptr_ff :
                        hit_poll ? {16'h0000, pollv_ff} :
                        hit_stat ? stat_rd : 32'h00000000;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata = prdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Fetch side decode.
   wire [1:0] last_beat = `DESC_BEATS - 2'h1;
   wire beat_done = (fst_ff == F_DATA) & rd_valid;
   wire is_last = beat_done & (beat_ff == last_beat);
   wire owned = rd_data[`DESC_OWNER_BIT];
   wire list_end = is_last & ~owned;
   wire end_stop = list_end & ~poll_ff;
   wire end_poll = list_end & poll_ff;
   wire full = (wp_ff[`PTR_AW] != rp_ff[`PTR_AW]) & ptr_eq(wp_ff, rp_ff);
   wire empty = wp_ff == rp_ff;
   wire send_ok = src_valid & src_ready;
   wire flush_done = rst_ff & (fst_ff == F_IDLE) & (wst_ff == W_IDLE);

   assign rd_read = fst_ff == F_RD;
   assign rd_addr = nptr_ff + {25'h0, beat_ff, 5'h00};
   assign rd_burst = burst_len(`BURST_EN);
   // Holding valid through a reset request keeps the stream handshake legal.
   assign src_valid = (fst_ff == F_SEND) & ~full;
   assign src_data = desc_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Response side decode.
   assign rsp_ready = (wst_ff == W_IDLE) & ~empty & ~rst_ff;
   wire rsp_take = rsp_valid & rsp_ready;
   wire tc_evt = rsp_data.tc_mask;
   wire et_evt = rsp_data.early & rsp_data.et_mask;
   wire err_evt = |(rsp_data.err & rsp_data.err_mask);
   wire rsp_evt = rsp_take & (tc_evt | et_evt | err_evt);
   wire irq_set = rsp_evt | end_stop;
   wire irq_w1c = stat_wr & pwdata[`STAT_IRQ];

   assign wr_write = wst_ff == W_WR;
   assign wr_addr = mem_q;
   assign wr_data = wb_word;
   assign wr_be = `WB_BE;
   assign irq = `PREFETCH_EN ? (irq_ff & gie_ff) : disp_irq;

   always_comb begin
      wb_word = '0;
      wb_word[`WB_BYTES_LSB +: 32] = rsp_ff.bytes;
      wb_word[`WB_ERR_LSB +: 8] = rsp_ff.err;
      wb_word[`WB_EARLY_BIT] = rsp_ff.early;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register next values. A hardware set wins over a clear in the same cycle.
   assign nxt_run = ctrl_wr ? pwdata[`CTRL_RUN] : ((end_stop | flush_done) ? 1'b0 : run_ff);
   assign nxt_rst = (ctrl_wr & pwdata[`CTRL_RST]) | (rst_ff & ~flush_done);
   assign nxt_irq = irq_set | (irq_ff & ~irq_w1c);
   assign nxt_nptr = nptr_wr ? pwdata : (send_ok ? next_ff : nptr_ff);
   assign nxt_beat = is_last ? 2'h0 : (beat_done ? beat_ff + 2'h1 : beat_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 1'b0;
         poll_ff <= 1'b0;
         rst_ff <= 1'b0;
         gie_ff <= 1'b0;
         irq_ff <= 1'b0;
         nptr_ff <= `NPTR_RST;
         pollv_ff <= `POLL_RST;
         prdata_ff <= 32'h00000000;
      end else begin
         run_ff <= nxt_run;
         rst_ff <= nxt_rst;
         irq_ff <= nxt_irq;
         nptr_ff <= nxt_nptr;
         if (ctrl_wr) begin
            poll_ff <= pwdata[`CTRL_POLL];
            gie_ff <= pwdata[`CTRL_GIE];
         end
         if (poll_wr) begin
            pollv_ff <= pwdata[`POLL_W-1:0];
         end
         if (apb_setup_rd) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fetch machine. A fetch in flight always finishes before a reset takes it idle.
   always_comb begin
      nxt_fst = fst_ff;
      case (fst_ff)
         F_IDLE: begin
            if (run_ff & ~rst_ff) begin
               nxt_fst = F_RD;
            end
         end
         F_RD: begin
            if (~rd_wait) begin
               nxt_fst = F_DATA;
            end
         end
         F_DATA: begin
            if (beat_done & ~is_last) begin
               nxt_fst = `BURST_EN ? F_DATA : F_RD;
            end else if (is_last) begin
               if (rst_ff | end_stop) begin
                  nxt_fst = F_IDLE;
               end else if (end_poll) begin
                  nxt_fst = (pollv_ff == 16'h0000) ? F_RD : F_POLL;
               end else begin
                  nxt_fst = F_SEND;
               end
            end
         end
         F_SEND: begin
            if (send_ok) begin
               nxt_fst = rst_ff ? F_IDLE : F_RD;
            end
         end
         F_POLL: begin
            if (rst_ff) begin
               nxt_fst = F_IDLE;
            end else if (cnt_ff == 16'h0000) begin
               nxt_fst = F_RD;
            end
         end
         default: nxt_fst = F_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fst_ff <= F_IDLE;
         beat_ff <= 2'h0;
         cnt_ff <= 16'h0000;
         next_ff <= 32'h00000000;
         desc_ff <= '0;
      end else begin
         fst_ff <= nxt_fst;
         beat_ff <= nxt_beat;
         if (end_poll) begin
            cnt_ff <= pollv_ff - 16'h0001;
         end else if ((fst_ff == F_POLL) & (cnt_ff != 16'h0000)) begin
            cnt_ff <= cnt_ff - 16'h0001;
         end
         if (beat_done & (beat_ff == 2'h0)) begin
            desc_ff <= rd_data;
         end
         if (is_last) begin
            next_ff <= rd_data[`DESC_NEXT_LSB +: 32];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer buffer: each sent descriptor's address waits here for its response.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         if (send_ok) begin
            wp_ff <= wp_ff + 4'h1;
         end
         if (flush_done) begin
            rp_ff <= send_ok ? wp_ff + 4'h1 : wp_ff;
         end else if (rsp_take) begin
            rp_ff <= rp_ff + 4'h1;
         end
      end
   end

   ptr_mem #(
      .DEPTH(`PTR_DEPTH),
      .AW(`PTR_AW)
   ) u_ptr_mem (
      .pclk(pclk),
      .presetn(presetn),
      .we(send_ok),
      .waddr(wp_ff[`PTR_AW-1:0]),
      .wdata(nptr_ff),
      .re(rsp_take),
      .raddr(rp_ff[`PTR_AW-1:0]),
      .rdata(mem_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write-back machine: one response at a time, address read from the buffer.
   always_comb begin
      nxt_wst = wst_ff;
      case (wst_ff)
         W_IDLE: begin
            if (rsp_take) begin
               nxt_wst = W_RD;
            end
         end
         W_RD: nxt_wst = W_WR;
         W_WR: begin
            if (~wr_wait) begin
               nxt_wst = W_IDLE;
            end
         end
         default: nxt_wst = W_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wst_ff <= W_IDLE;
         rsp_ff <= '0;
      end else begin
         wst_ff <= nxt_wst;
         if (rsp_take) begin
            rsp_ff <= rsp_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ready_in_reset;
      rst_ff |-> !rsp_ready;
   endproperty
   a_ready_in_reset: assert property (p_ready_in_reset) else $error("response taken during reset");

   property p_masked_event;
      (rsp_take && rsp_data.tc_mask) |=> irq_ff;
   endproperty
   a_masked_event: assert property (p_masked_event) else $error("masked completion lost");

   property p_irq_out;
      (irq_ff && gie_ff) |-> irq ##1 (irq_ff || !irq);
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq output wrong");

   property p_w1c_hold;
      (irq_ff && !irq_w1c) |=> irq_ff;
   endproperty
   a_w1c_hold: assert property (p_w1c_hold) else $error("irq flag lost without clear");

   property p_stop_at_end;
      (end_stop && !ctrl_wr) |=> (!run_ff && irq_ff && fst_ff == F_IDLE) ##1 !rd_read;
   endproperty
   a_stop_at_end: assert property (p_stop_at_end) else $error("list end not stopped");

   property p_poll_wait;
      (end_poll && !rst_ff && pollv_ff > 16'h0001) |=> (fst_ff == F_POLL && cnt_ff == $past(pollv_ff) - 16'h0001);
   endproperty
   a_poll_wait: assert property (p_poll_wait) else $error("poll interval not loaded");

   property p_follow_next;
      (send_ok && !nptr_wr) |=> nptr_ff == $past(next_ff);
   endproperty
   a_follow_next: assert property (p_follow_next) else $error("next pointer not followed");

   property p_reset_done;
      (flush_done && !ctrl_wr) |=> (!rst_ff && !run_ff && !busy);
   endproperty
   a_reset_done: assert property (p_reset_done) else $error("reset bit not cleared");

   property p_start;
      (fst_ff == F_IDLE && run_ff && !rst_ff && !nptr_wr) |=> (rd_read && rd_addr == $past(nptr_ff));
   endproperty
   a_start: assert property (p_start) else $error("fetch not started at pointer");

   property p_writeback;
      rsp_take |-> ##2 (wr_write && wr_data[`WB_BYTES_LSB +: 32] == $past(rsp_data.bytes, 2));
   endproperty
   a_writeback: assert property (p_writeback) else $error("status write-back missing");
endmodule

/* File: sim/disp_model.sv */
// Dispatcher stand-in: takes descriptors and returns one completion response for each, in order, save those a software reset drops.
// Assumes the response fields sit in the low 52 bits of every descriptor the bench builds.
`timescale 1ns/10ps
module disp_model
   import pf_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Descriptor intake.
   input wire logic src_valid,
   input wire logic [255:0] src_data,
   output logic src_ready,
   // Response stream.
   output logic rsp_valid,
   output resp_t rsp_data,
   input wire logic rsp_ready,
   // Response delay, software reset and count of descriptors taken.
   input wire logic [3:0] dly,
   input wire logic sw_rst,
   output int n_got
);
   logic [51:0] q[$];
   logic [3:0] wait_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '1;
         wait_ff <= 4'h0;
         n_got = 0;
         q.delete();
      end else if (sw_rst) begin
         // A software reset drops every response still held for the prefetcher.
         rsp_valid <= 1'b0;
         wait_ff <= 4'h0;
         q.delete();
      end else begin
         // A slow dispatcher also stalls the descriptor source every other cycle.
         src_ready <= ~src_ready | (dly == 4'h0);
         if (src_valid && src_ready) begin
            q.push_back(src_data[51:0]);
            n_got++;
         end
         if (rsp_valid && !rsp_ready) begin
            rsp_valid <= 1'b1;
         end else if (q.size() > 0 && wait_ff >= dly) begin
            rsp_valid <= 1'b1;
            rsp_data <= {204'h0, q.pop_front()};
            wait_ff <= 4'h0;
         end else begin
            // Released data must not look like the last word.
            rsp_valid <= 1'b0;
            rsp_data <= ~rsp_data;
            wait_ff <= wait_ff + 4'h1;
         end
      end
   end
endmodule

/* File: sim/tb.sv */
// Self-checking bench of the descriptor prefetcher with a memory and a dispatcher model.
// Assumes the register map and descriptor layout of pf_regs.svh.
`timescale 1ns/10ps
`include "pf_regs.svh"
module tb
   import pf_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, slv;
   logic rd_read, rd_valid = 1'b0, rd_wait = 1'b0;
   logic [31:0] rd_addr, wr_addr;
   logic [255:0] rd_data = '0, wr_data, src_data;
   logic wr_write, wr_wait = 1'b0, src_valid, src_ready, rsp_valid, rsp_ready, irq;
   logic disp_irq = 1'b1;
   logic [31:0] wr_be;
   resp_t rsp_data;
   logic [3:0] dly = 4'h0;
   logic drst = 1'b0;
   logic [4:0] rd_burst;
   logic [255:0] mem[logic [31:0]];
   int n_got, n_rd = 0, n_wb = 0, fails = 0, n_tests = 0, cyc = 0;

   desc_prefetch desc_prefetch_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .rd_read, .rd_addr, .rd_burst, .rd_wait, .rd_valid, .rd_data, .wr_write,
      .wr_addr, .wr_data, .wr_be, .wr_wait, .src_valid, .src_data, .src_ready, .rsp_valid, .rsp_data,
      .rsp_ready, .disp_irq, .irq);
   disp_model disp_model_i (.pclk, .presetn, .src_valid, .src_data, .src_ready, .rsp_valid, .rsp_data,
      .rsp_ready, .dly, .sw_rst(drst), .n_got);

   always #20 pclk = ~pclk;

   // Descriptor memory: both ports stall every other cycle.
   always @(posedge pclk) begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      rd_wait <= ~rd_wait;
      wr_wait <= ~wr_wait;
      cyc++;
      if (rd_read && !rd_wait) begin
         rd_valid <= 1'b1;
         rd_data <= mem[rd_addr];
         n_rd++;
      end
      if (wr_write && !wr_wait) begin
         for (int i = 0; i < 32; i++) begin
            if (wr_be[i]) mem[wr_addr][8*i +: 8] = wr_data[8*i +: 8];
         end
         n_wb++;
      end
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////
   function automatic logic [255:0] desc(input logic own, input logic [31:0] nxt, input logic [51:0] f);
      desc = '0;
      desc[254] = own;
      desc[127:96] = nxt;
      desc[51:0] = f;
   endfunction

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      for (int k = 0; k < 100; k++) begin
         apb(a, 1'b0, 32'h0);
         if ((rdv & m) === v) break;
      end
   endtask

   task automatic wait_n(ref int c, input int n);
      for (int k = 0; k < 400 && c < n; k++) @(posedge pclk);
      chk(32'(c >= n), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] offs[4] = '{`CTRL_OFF, `NPTR_OFF, `POLL_OFF, `STAT_OFF};
      chk(irq, 1'b0);
      chk(rd_burst, 32'h1);
      foreach (offs[i]) begin
         apb(offs[i], 1'b0, 32'h0);
         chk(rdv, 32'h0);
      end
      apb(8'h10, 1'b1, 32'hffffffff);
      chk(slv, 1'b1);
      apb(8'h10, 1'b0, 32'h0);
      chk(rdv, 32'h0);
   endtask

   // Two owned descriptors back to back, then an unowned one ends the list.
   task automatic t_list();
      mem[32'h100] = desc(1'b1, 32'h120, {12'h0, 8'h00, 32'h11});
      mem[32'h120] = desc(1'b1, 32'h140, {11'h0, 1'b1, 8'h05, 32'h22});
      mem[32'h140] = desc(1'b0, 32'h0, 52'h0);
      apb(`NPTR_OFF, 1'b1, 32'h100);
      apb(`CTRL_OFF, 1'b1, 32'h9);
      wait_n(n_wb, 2);
      poll(`STAT_OFF, 32'h1, 32'h1);
      chk(mem[32'h100][159:128], 32'h11);
      chk(mem[32'h120][168:160], 32'h105);
      chk(n_got, 2);
      chk(rdv & 32'h1, 32'h1);
      apb(`CTRL_OFF, 1'b0, 32'h0);
      chk(rdv & 32'h1, 32'h0);
      chk(irq, 1'b1);
      apb(`CTRL_OFF, 1'b1, 32'h0);
      apb(`STAT_OFF, 1'b0, 32'h0);
      chk(irq, 1'b0);
      chk(rdv & 32'h1, 32'h1);
      apb(`CTRL_OFF, 1'b1, 32'h8);
      apb(`STAT_OFF, 1'b1, 32'h0);
      apb(`STAT_OFF, 1'b0, 32'h0);
      chk(rdv & 32'h1, 32'h1);
      apb(`STAT_OFF, 1'b1, 32'h1);
      apb(`STAT_OFF, 1'b0, 32'h0);
      chk(rdv & 32'h1, 32'h0);
      chk(irq, 1'b0);
   endtask

   // Polling mode with a slow dispatcher; each case hands one descriptor with its masks.
   task automatic t_poll();
      logic [51:0] f[5] = '{{2'h0, 8'h04, 2'h0, 8'h04, 32'h1}, {2'h0, 8'h08, 2'h0, 8'h04, 32'h2},
         {10'h0, 1'b1, 1'b0, 8'h0, 32'h3}, {2'h1, 8'h0, 1'b0, 1'b1, 8'h0, 32'h4}, {11'h0, 1'b1, 8'h0, 32'h5}};
      logic e[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      int g0, w0, r0;
      dly <= 4'h3;
      mem[32'h400] = desc(1'b0, 32'h0, 52'h0);
      g0 = n_got;
      w0 = n_wb;
      r0 = n_rd;
      apb(`POLL_OFF, 1'b1, 32'h4);
      apb(`NPTR_OFF, 1'b1, 32'h400);
      apb(`CTRL_OFF, 1'b1, 32'hb);
      wait_n(n_rd, r0 + 3);
      chk(n_got, g0);
      for (int i = 0; i < 5; i++) begin
         mem[32'h420 + 32 * i] = desc(1'b0, 32'h0, 52'h0);
         mem[32'h400 + 32 * i] = desc(1'b1, 32'h420 + 32 * i, f[i]);
         wait_n(n_wb, w0 + 1 + i);
         apb(`STAT_OFF, 1'b0, 32'h0);
         chk(rdv & 32'h1, e[i]);
         chk(irq, e[i]);
         apb(`STAT_OFF, 1'b1, 32'h1);
      end
      chk(n_got, g0 + 5);
   endtask

   task automatic t_prst();
      apb(`CTRL_OFF, 1'b1, 32'hf);
      poll(`CTRL_OFF, 32'h4, 32'h0);
      chk(rdv & 32'h5, 32'h0);
      drst <= 1'b1;
      @(posedge pclk);
      drst <= 1'b0;
      @(posedge pclk);
      chk(rsp_valid, 1'b0);
   endtask

   task automatic report_and_stop();
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_list();
      t_poll();
      t_prst();
      report_and_stop();
   end
endmodule
